// ---- rtl/pts_cfg.svh ----
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH

// register indices; byte address is four times the index
`define PTS_IDX_CTL 12'h042
`define PTS_IDX_PLD 12'h043
`define PTS_IDX_DAT 12'h044
`define PTS_ADDR_W 12

// control register field positions
`define PTS_CTL_SBD 0
`define PTS_CTL_EN 1
`define PTS_CTL_SEL_LO 2
`define PTS_CTL_TXB 4
`define PTS_CTL_RXB 5
`define PTS_CTL_RXL 6
`define PTS_CTL_TXOE 7

// reset values
`define PTS_CTL_RST 8'h00
`define PTS_PLD_RST 8'h00
`define PTS_CNT_RST 8'h00
`define PTS_CNT_MAX 8'hFF

// auxiliary clock nominal rate and master clock rate
`define PTS_ACLK_HZ 32768
`define PTS_MCLK_HZ 200000000

`endif

// ---- rtl/pts_pkg.sv ----
package pts_pkg;

	// counting clock choice
	typedef enum logic [1:0] {
		CK_MCLK = 2'b00,
		CK_ACLK = 2'b01,
		CK_PIN = 2'b10,
		CK_AND = 2'b11
	} pts_clksel_t;

	// start-bit detector states
	typedef enum logic [2:0] {
		ST_OFF = 3'b001,
		ST_ARM = 3'b010,
		ST_RUN = 3'b100
	} pts_state_t;

	// control register image, msb first
	typedef struct packed {
		logic tx_oe;
		logic rx_level;
		logic rx_bit;
		logic tx_bit;
		pts_clksel_t clksel;
		logic cnt_en;
		logic sbd_en;
	} pts_ctl_t;

	// apb request as seen by the slave
	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} pts_apb_req_t;

endpackage : pts_pkg

// ---- rtl/pts_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module pts_sync
#(
	parameter int W = 2,
	parameter logic [W-1:0] INIT = '0
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// asynchronous inputs
	input wire logic [W-1:0] async_in,
	// synchronised level and edges
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	logic [W-1:0] prev_r;

	// two-flop chain; only sync_r reads meta_r
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			// stages start at the idle level: no false edge after reset
			meta_r <= INIT;
			sync_r <= INIT;
			prev_r <= INIT;
		end
		else
		begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// edges come from settled stages only
	assign level = sync_r;
	assign rise = sync_r & ~prev_r;
	assign fall = ~sync_r & prev_r;

endmodule : pts_sync

`default_nettype wire

// ---- rtl/pts_timer.sv ----
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pts_cfg.svh"

// Operation
// - 8-bit counter, preload and control registers
// - two control bits select counting clock
// - master, auxiliary, pin, or master AND pin
// - counter write loads preload value instead
// - preload readable, writable, rewritable after load
// - enable high counts rising edges, else holds
// - start-bit detect holds counter until edge
// - first interval end samples receive level
// - both latches clocked at each interval end
// - latches triggered by counter carry-out
// - one bit per interval, software supplies bits
// - timer shares port pins one and two
// - auxiliary clock is the watch crystal

module pts_timer
	import pts_pkg::*;
#(
	parameter int AW = `PTS_ADDR_W
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic [AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// clocks and pins
	input wire logic aclk,
	input wire logic timer_input_pin,
	output logic timer_output_pin,
	output logic timer_output_pin_oe,
	// status
	output logic carry_out
);

	localparam logic [AW-1:0] A_CTL = AW'(`PTS_IDX_CTL * 4);
	localparam logic [AW-1:0] A_PLD = AW'(`PTS_IDX_PLD * 4);
	localparam logic [AW-1:0] A_DAT = AW'(`PTS_IDX_DAT * 4);

	pts_ctl_t ctl_r;
	logic [7:0] pld_r;
	logic [7:0] cnt_r;
	logic carry_r;
	logic receive_bit_latch_r;
	logic transmit_bit_latch_r;
	pts_state_t state_r;
	pts_state_t state_nxt;
	logic [31:0] prdata_r;
	logic [1:0] s_level;
	logic [1:0] s_rise;
	logic [1:0] s_fall;
	logic rx_level;
	logic rx_fall;
	logic tick;
	logic adv;
	logic sbd_hold;
	logic wr;
	logic rd_setup;
	logic load;
	logic wrap;

	// map an address to a known register
	function automatic logic is_mapped(input logic [AW-1:0] a);
		is_mapped = (a == A_CTL) || (a == A_PLD) || (a == A_DAT);
	endfunction : is_mapped

	// bit 0 is the crystal clock, bit 1 the shared port pin
	// receive line idles high, so its stages reset high
	pts_sync #(
		.W(2),
		.INIT(2'b10)
	) u_sync (
		.mclk(mclk),
		.rst(rst),
		.async_in({timer_input_pin, aclk}),
		.level(s_level),
		.rise(s_rise),
		.fall(s_fall)
	);

	// receive data shares the timer input pin
	assign rx_level = s_level[1];
	assign rx_fall = s_fall[1];

	// apb strobes; zero wait states
	assign wr = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign load = wr && (paddr == A_DAT);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !is_mapped(paddr);
	assign prdata = prdata_r;

	// counting clock select; aclk edges are crystal rate
	always_comb
	begin
		case (ctl_r.clksel)
			CK_MCLK: tick = 1'b1;
			CK_ACLK: tick = s_rise[0];
			CK_PIN: tick = s_rise[1];
			CK_AND: tick = s_level[1];
			default: tick = 1'b0;
		endcase
	end

	// while detection is on, the count waits for the start edge
	// this also covers the one cycle before the detector arms
	assign sbd_hold = ctl_r.sbd_en && (state_r != ST_RUN);
	assign adv = tick && ctl_r.cnt_en && !sbd_hold;
	assign wrap = adv && !load && (cnt_r == `PTS_CNT_MAX);

	// start-bit detector; idle line high, start is a fall
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF:
				if (ctl_r.sbd_en)
					state_nxt = ST_ARM;
			ST_ARM:
				if (!ctl_r.sbd_en)
					state_nxt = ST_OFF;
				else if (rx_fall)
					state_nxt = ST_RUN;
			ST_RUN:
				if (!ctl_r.sbd_en)
					state_nxt = ST_OFF;
			default: state_nxt = ST_OFF;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			state_r <= ST_OFF;
		else
			state_r <= state_nxt;
	end

	// control register; read-only bits never stored
	always_ff @(posedge mclk)
	begin
		if (rst)
			ctl_r <= `PTS_CTL_RST;
		else if (wr && paddr == A_CTL)
		begin
			ctl_r <= pwdata[7:0];
			ctl_r.rx_level <= 1'b0;
			ctl_r.rx_bit <= 1'b0;
		end
	end

	// preload is a plain buffer; a load leaves it untouched
	always_ff @(posedge mclk)
	begin
		if (rst)
			pld_r <= `PTS_PLD_RST;
		else if (wr && paddr == A_PLD)
			pld_r <= pwdata[7:0];
	end

	// counter: load wins over a coincident count tick
	always_ff @(posedge mclk)
	begin
		if (rst)
			cnt_r <= `PTS_CNT_RST;
		else if (load)
			cnt_r <= pld_r;
		else if (adv)
			cnt_r <= 8'(cnt_r + 8'h01);
	end

	// carry stands for one counting-clock period
	always_ff @(posedge mclk)
	begin
		if (rst)
			carry_r <= 1'b0;
		else if (wrap)
			carry_r <= 1'b1;
		else if (adv || load)
			carry_r <= 1'b0;
	end

	// data latches clocked by the carry event
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			receive_bit_latch_r <= 1'b0;
			transmit_bit_latch_r <= 1'b1;
		end
		else if (wrap)
		begin
			receive_bit_latch_r <= rx_level;
			transmit_bit_latch_r <= ctl_r.tx_bit;
		end
	end

	// output pin driven from the latch; idle mark level
	assign timer_output_pin = transmit_bit_latch_r;
	assign timer_output_pin_oe = ctl_r.tx_oe;
	assign carry_out = carry_r;

	// read data captured in setup, shown in access
	always_ff @(posedge mclk)
	begin
		if (rst)
			prdata_r <= 32'h0000_0000;
		else if (rd_setup)
		begin
			if (paddr == A_CTL)
				prdata_r <= {24'h00_0000, ctl_r.tx_oe, rx_level,
					receive_bit_latch_r, ctl_r.tx_bit,
					ctl_r.clksel, ctl_r.cnt_en, ctl_r.sbd_en};
			else if (paddr == A_PLD)
				prdata_r <= {24'h00_0000, pld_r};
			else if (paddr == A_DAT)
				prdata_r <= {24'h00_0000, cnt_r};
			else
				prdata_r <= 32'h0000_0000;
		end
	end

	// checks on the counting path
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_load_copy_pld: assert property (
		load |=> cnt_r == $past(pld_r))
		else $error("counter write did not load preload");

	a_pld_written: assert property (
		wr && paddr == A_PLD |=> pld_r == $past(pwdata[7:0])
			&& ($stable(cnt_r) || $past(adv)))
		else $error("preload write lost");

	a_count_holds: assert property (
		!ctl_r.cnt_en && !load |=> $stable(cnt_r))
		else $error("counter moved while disabled");

	a_mclk_counts: assert property (
		ctl_r.clksel == CK_MCLK && ctl_r.cnt_en && !sbd_hold
			&& !load |=> cnt_r == 8'($past(cnt_r) + 8'h01))
		else $error("master clock count missed");

	a_armed_idle: assert property (
		state_r == ST_ARM && !load |=> $stable(cnt_r))
		else $error("counter ran before start bit");

	a_start_seen: assert property (
		state_r == ST_ARM && ctl_r.sbd_en && rx_fall
			|=> state_r == ST_RUN)
		else $error("start edge not detected");

	a_wrap_carry: assert property (
		wrap |=> carry_r && cnt_r == 8'h00)
		else $error("wrap did not raise carry");

	a_carry_single: assert property (
		carry_r && adv && !load |=> !carry_r)
		else $error("carry held past one count");

	a_rx_sampled: assert property (
		wrap |=> receive_bit_latch_r == $past(rx_level))
		else $error("receive level not sampled at carry");

	a_tx_driven: assert property (
		wrap |=> timer_output_pin == $past(ctl_r.tx_bit))
		else $error("transmit latch not clocked at carry");

	a_latch_quiet: assert property (
		!wrap |=> $stable(receive_bit_latch_r)
			&& $stable(transmit_bit_latch_r))
		else $error("latch moved without carry");

	// register path: read-only bits, output enable, read-back
	a_ctl_ro_bits: assert property (
		wr && paddr == A_CTL |=> ctl_r
			== {$past(pwdata[7]), 2'b00, $past(pwdata[4:0])})
		else $error("control write reached read-only bits");

	a_oe_follows: assert property (
		wr && paddr == A_CTL
			|=> timer_output_pin_oe == $past(pwdata[7]))
		else $error("output enable did not follow control write");

	a_pld_readback: assert property (
		rd_setup && paddr == A_PLD
			|=> prdata == {24'h00_0000, $past(pld_r)})
		else $error("preload read-back wrong");

	a_dat_readback: assert property (
		rd_setup && paddr == A_DAT
			|=> prdata == {24'h00_0000, $past(cnt_r)})
		else $error("count read-back wrong");

	// clock sources: pin choice counts on each pin rise; crystal and pin AND master choices hold the count between their own ticks
	a_pin_counts: assert property (
		ctl_r.clksel == CK_PIN && ctl_r.cnt_en && !sbd_hold
			&& s_rise[1] && !load |=> cnt_r == 8'($past(cnt_r) + 8'h01))
		else $error("pin edge did not count");

	a_and_gated: assert property (
		ctl_r.clksel == CK_AND && !s_level[1] && !load
			|=> $stable(cnt_r))
		else $error("gated count moved with pin low");

	a_aclk_gated: assert property (
		ctl_r.clksel == CK_ACLK && !s_rise[0] && !load
			|=> $stable(cnt_r))
		else $error("count moved between crystal edges");

	// serial path: hold before the start edge, carry width, pin sync
	a_arm_hold: assert property (
		sbd_hold && !load |=> $stable(cnt_r))
		else $error("counter ran before detector saw start");

	a_carry_stands: assert property (
		carry_r && !adv && !load |=> carry_r)
		else $error("carry dropped before next count");

	// two-flop delay keeps a marginal edge out of the latch
	a_rx_synced: assert property (
		!$past(rst) && !$past(rst, 2)
			|-> rx_level == $past(timer_input_pin, 2))
		else $error("receive pin not passed through two flops");

	c_start_then_carry: cover property (
		state_r == ST_ARM ##1 state_r == ST_RUN ##[1:600] wrap);
	c_load_seen: cover property (load);
	c_pin_and_mode: cover property (ctl_r.clksel == CK_AND && adv);
	c_aclk_mode: cover property (ctl_r.clksel == CK_ACLK && wrap);
	c_pin_count: cover property (ctl_r.clksel == CK_PIN && adv);

endmodule : pts_timer

`default_nettype wire

// ---- tb/pts_serial_dev.sv ----
`timescale 1ns/1ps
`default_nettype none

module pts_serial_dev
(
	// clock
	input wire logic mclk,
	// lines seen from the far side
	input wire logic tx_pin,
	input wire logic tx_oe,
	output logic rx_pin
);
	logic last_tx;

	// idle line rests at mark, so the first low is a start bit
	initial rx_pin = 1'b1;

	// level changes land just after an edge
	task automatic set_level(input logic b);
		@(posedge mclk);
		rx_pin <= b;
	endtask : set_level

	// pulses wide enough to pass the two-flop synchroniser
	task automatic pulse(input int n);
		repeat (n)
		begin
			set_level(1'b1);
			repeat (3) @(posedge mclk);
			set_level(1'b0);
			repeat (3) @(posedge mclk);
		end
	endtask : pulse

	// a released transmit line tells nothing, so only driven bits count
	always_ff @(posedge mclk)
		if (tx_oe)
			last_tx <= tx_pin;
endmodule : pts_serial_dev
`default_nettype wire

// ---- tb/preload_timer_serial_assist_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pts_cfg.svh"

module preload_timer_serial_assist_tb_top import pts_pkg::*;;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, aclk;
	logic rx, tx, tx_oe, carry, e, txb, rxb;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [7:0] a, b;
	int miscompares, total_checks, seed, m, p, k, n;
	// reference model of preload and count, and queued transmit bits
	int mpld, mcnt;
	logic txq[$];

	pts_timer u_dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .aclk(aclk),
		.timer_input_pin(rx), .timer_output_pin(tx),
		.timer_output_pin_oe(tx_oe), .carry_out(carry));
	pts_serial_dev u_dev (.mclk(mclk), .tx_pin(tx), .tx_oe(tx_oe),
		.rx_pin(rx));

	// clocks; aux far faster than a crystal to keep the run short
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x)
		begin
			miscompares++;
			$display("FAIL %0t got %h exp %h", $time, g, x);
		end
	endtask : chk

	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] i,
		input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i[9:0], 2'b00};
		pwdata <= {24'h0000_00, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		// the model takes a write at the same edge as the design
		if (w && i == `PTS_IDX_PLD)
			mpld = d;
		if (w && i == `PTS_IDX_DAT)
			mcnt = mpld;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] i, input logic [7:0] x);
		apb(1'b0, i, 8'h00);
		chk(r, {24'h0000_00, x});
	endtask : rd

	task automatic wcarry;
		int c;
		c = 0;
		while (carry !== 1'b1 && c < 600)
		begin
			@(posedge mclk);
			#1;
			c++;
		end
		chk(c < 600, 1);
	endtask : wcarry

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// watchdog well beyond the several hundred cycles needed
	initial
	begin
		#200000;
		miscompares++;
		end_sim();
	end

	initial
	begin
		seed = 32'h89c3_8007;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		rd(`PTS_IDX_CTL, 8'h40);
		chk(e, 1'b0);
		chk(pready, 1'b1);
		rd(`PTS_IDX_PLD, 8'h00);
		rd(`PTS_IDX_DAT, 8'h00);
		chk({tx, tx_oe, carry}, 3'b100);
		rd(12'h050, 8'h00);
		chk(e, 1'b1);
		// a write to a hole is refused and changes nothing
		apb(1'b1, 12'h050, 8'hFF);
		chk(e, 1'b1);
		rd(`PTS_IDX_CTL, 8'h40);
		$display("test reset done");
		// preload rewritten after a load must not touch the count
		a = 8'($random(seed));
		b = 8'($random(seed));
		apb(1'b1, `PTS_IDX_PLD, a);
		apb(1'b1, `PTS_IDX_DAT, 8'h55);
		apb(1'b1, `PTS_IDX_PLD, b);
		rd(`PTS_IDX_DAT, mcnt[7:0]);
		rd(`PTS_IDX_PLD, mpld[7:0]);
		$display("test preload done");
		// every clock choice with the pin held low and high
		for (m = 0; m < 4; m++)
			for (p = 0; p < 2; p++)
			begin
				u_dev.set_level(p[0]);
				apb(1'b1, `PTS_IDX_CTL, {4'h0, m[1:0], 2'b10});
				apb(1'b1, `PTS_IDX_DAT, 8'h00);
				repeat (40) @(posedge mclk);
				apb(1'b1, `PTS_IDX_CTL, 8'h00);
				apb(1'b0, `PTS_IDX_DAT, 8'h00);
				chk(r[7:0] != b, m != 2 && (m != 3 || p == 1));
			end
		$display("test clock choice done");
		// each pin rising edge is one count
		n = 1 + $unsigned($random(seed)) % 9;
		u_dev.set_level(1'b0);
		apb(1'b1, `PTS_IDX_PLD, 8'h00);
		apb(1'b1, `PTS_IDX_CTL, 8'h0A);
		apb(1'b1, `PTS_IDX_DAT, 8'h00);
		u_dev.pulse(n);
		repeat (6) @(posedge mclk);
		rd(`PTS_IDX_DAT, 8'(mcnt + n));
		$display("test pin count done");
		// serial bits: armed hold, start edge, latches move at the wrap
		apb(1'b1, `PTS_IDX_PLD, 8'hF8);
		for (k = 0; k < 4; k++)
		begin
			txb = 1'($random(seed));
			rxb = 1'($random(seed));
			txq.push_back(txb);
			u_dev.set_level(1'b1);
			apb(1'b1, `PTS_IDX_CTL, {3'b100, txb, 4'h2});
			apb(1'b1, `PTS_IDX_CTL, {3'b100, txb, 4'h3});
			apb(1'b1, `PTS_IDX_DAT, 8'h00);
			repeat (8) @(posedge mclk);
			rd(`PTS_IDX_DAT, mcnt[7:0]);
			u_dev.set_level(1'b0);
			repeat (2) @(posedge mclk);
			u_dev.set_level(rxb);
			wcarry();
			chk(tx, txq.pop_front());
			chk(tx_oe, 1'b1);
			@(posedge mclk);
			#1;
			chk(carry, 1'b0);
			chk(u_dev.last_tx, txb);
			rd(`PTS_IDX_CTL, {1'b1, rxb, rxb, txb, 4'h3});
		end
		$display("test serial done");
		end_sim();
	end
endmodule : preload_timer_serial_assist_tb_top
`default_nettype wire
